// ### lvdsd_rx.sv
// How it works
// [R1] four serial lanes plus forwarded clock become one 28-bit word
// [R2] each lane sampled seven times per clock period, evenly spaced
// [R3] regenerated clock output; its rising edge strobes the word
// [R4] output clock high and low phases each near half a period
// [R5] a word appears two forwarded clock periods after it arrives
// [R6] lock within 10 ms; outputs need not be valid before lock
// [R7] power-down low forces word and clock outputs low
// [R8] power-down takes effect within 1 microsecond
// [R9] undriven lanes read high; with clock present the word goes all high
// [R10] lanes and clock both undriven: word holds last valid value
// [R11] forwarded clock undriven: regenerated clock held low
// [R12] transmitter supplies a forwarded clock between 20 and 75 MHz; the tx model runs a 64 ns clock, 15.625 MHz
// [R13] lane slot to word bit mapping comes from one shared table
////////////////////////////////////////////////////////////////////////
// Purpose: seven-to-one deserializer behind the link pins
// Assumes: lanes are 1 when undriven; clock input reads 0 when undriven;
//   the sampled link is slow enough that clk_sys oversamples each bit slot
// Notes: bit slots are taken by phase, measured in system cycles since the
//   last forwarded clock rise; the period is averaged over the last few periods
`timescale 1ns/1ps
module lvdsd_rx
  import lvdsd_pkg::*;
#(
  parameter int LOCK_CYCLES = LVDSD_LOCK_CYCLES,
  parameter int PER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [LVDSD_LANES-1:0] serial_data_lane,
  input wire logic forwarded_clock_in,
  input wire logic power_down_n,
  output logic [LVDSD_WORD_W-1:0] parallel_word_out,
  output logic regenerated_clock_out,
  output logic locked
);
  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the lane, clock and power-down pins
  logic [LVDSD_LANES-1:0] lane_m, lane_s;
  logic fclk_m, fclk_s, fclk_d;
  logic pdn_m, pdn_s;
  always_ff @(posedge clk_sys) begin
    lane_m <= serial_data_lane;
    lane_s <= lane_m;
    fclk_m <= forwarded_clock_in;
    fclk_s <= fclk_m;
    fclk_d <= fclk_s;
    pdn_m <= power_down_n;
    pdn_s <= pdn_m;
  end
  wire fclk_rise = fclk_s & ~fclk_d;

  ////////////////////////////////////////////////////////////////////////
  // period measurement and clock-loss watch
  logic [PER_W-1:0] phase, period;
  logic [PER_W-1:0] idle_cnt;
  logic clk_lost;
  logic [PER_W-1:0] per_hist [LVDSD_AVG_PERIODS];
  logic [PER_W+2:0] per_sum;
  wire idle_sat = (idle_cnt >= PER_W'(LVDSD_CLK_LOST_CYCLES));
  // sum of recent periods keeps the fraction of a cycle that one period loses
  always_comb begin
    per_sum = '0;
    for (int i = 0; i < LVDSD_AVG_PERIODS; i++) begin
      per_sum = per_sum + (PER_W+3)'(per_hist[i]);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < LVDSD_AVG_PERIODS; i++) begin
        per_hist[i] <= '0;
      end
    end else if (fclk_rise) begin
      per_hist[0] <= phase + PER_W'(1);
      for (int i = 1; i < LVDSD_AVG_PERIODS; i++) begin
        per_hist[i] <= per_hist[i-1];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      phase <= '0;
      period <= '0;
      idle_cnt <= '0;
      clk_lost <= 1'b1;
    end else begin
      if (fclk_rise) begin
        period <= phase + PER_W'(1);
        phase <= '0;
        idle_cnt <= '0;
        clk_lost <= 1'b0;
      end else begin
        if (phase != '1) phase <= phase + PER_W'(1);
        if (!idle_sat) idle_cnt <= idle_cnt + PER_W'(1);
        else clk_lost <= 1'b1; // [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit slot strobes: slots 1 to 6 centred at (2k+1)/14 of the mean period, one cycle early
  // because the lanes seen at phase p were pinned p+1 cycles after the detected rise
  logic [LVDSD_LANES*LVDSD_SLOTS-1:0] shadow;
  logic [LVDSD_WORD_W-1:0] stage1;
  genvar gs, gl;
  generate
    for (gs = 0; gs < LVDSD_SLOTS; gs++) begin : g_slot
      wire [PER_W+7:0] num = (PER_W+8)'(per_sum) * (PER_W+8)'(2*gs+1);
      wire [PER_W-1:0] pos = PER_W'(num / (PER_W+8)'(2*LVDSD_SLOTS*LVDSD_AVG_PERIODS));
      // slot 0 is taken on the detected rise itself
      wire hit = (gs == 0) ? fclk_rise : ((phase + PER_W'(1) == pos) & ~fclk_rise); // [R2]
      for (gl = 0; gl < LVDSD_LANES; gl++) begin : g_lane
        always_ff @(posedge clk_sys) begin
          if (hit) shadow[gl*LVDSD_SLOTS+gs] <= lane_s[gl];
        end
      end
    end
  endgenerate

  // scatter slots into the word through the shared table
  logic [LVDSD_WORD_W-1:0] mapped;
  always_comb begin
    mapped = '0;
    for (int i = 0; i < LVDSD_WORD_W; i++) begin
      mapped[LVDSD_MAP[i]] = shadow[i]; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock: a run of steady periods, or a timeout
  lvdsd_state_e state;
  logic [2:0] good_edges;
  logic [31:0] lock_cnt;
  wire steady = fclk_rise && (phase + PER_W'(1) == period) && (period > PER_W'(LVDSD_SLOTS));
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= LVDSD_DOWN;
      good_edges <= '0;
      lock_cnt <= '0;
    end else begin
      case (state)
        LVDSD_DOWN: begin
          good_edges <= '0;
          lock_cnt <= '0;
          if (pdn_s && !clk_lost) state <= LVDSD_SEEK;
        end
        LVDSD_SEEK: begin
          if (!pdn_s || clk_lost) state <= LVDSD_DOWN;
          else if (good_edges == LVDSD_LOCK_EDGES || lock_cnt == 32'(LOCK_CYCLES)) state <= LVDSD_RUN; // [R6]
          else begin
            lock_cnt <= lock_cnt + 32'h1;
            if (steady) good_edges <= good_edges + 3'h1;
            else if (fclk_rise) good_edges <= '0;
          end
        end
        LVDSD_RUN: begin
          if (!pdn_s || clk_lost) state <= LVDSD_DOWN;
        end
        default: state <= LVDSD_DOWN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pipeline: word captured at rise n shows at rise n+2
  logic [LVDSD_WORD_W-1:0] next_word;
  logic half_mark;
  wire clk_high_end = (phase == (period >> 1));
  assign next_word = stage1; // [R5]
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stage1 <= '0;
      parallel_word_out <= '0;
      regenerated_clock_out <= 1'b0;
      locked <= 1'b0;
      half_mark <= 1'b0;
    end else begin
      locked <= (state == LVDSD_RUN);
      half_mark <= clk_high_end;
      if (!pdn_s) begin
        parallel_word_out <= '0; // [R7] [R8]
        regenerated_clock_out <= 1'b0;
      end else if (clk_lost) begin
        regenerated_clock_out <= 1'b0; // [R11] [R10]
      end else begin
        if (fclk_rise) begin
          stage1 <= mapped; // [R1] [R9]
          parallel_word_out <= next_word;
        end
        // rise one cycle after the word, so the word is set up first
        if (state == LVDSD_RUN && half_mark == 1'b0 && clk_high_end) regenerated_clock_out <= 1'b0; // [R4]
        else if (state == LVDSD_RUN && phase == '0) regenerated_clock_out <= 1'b1; // [R3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  power_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !pdn_s |=> (parallel_word_out == '0 && !regenerated_clock_out)) // [R7]
    else $error("outputs not low in power-down");
  pdn_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(power_down_n) |-> ##[1:3] (parallel_word_out == '0)) // [R8]
    else $error("power-down too slow");
  lost_clk_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_lost |=> !regenerated_clock_out) // [R11]
    else $error("clock out not low after clock loss");
  hold_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (clk_lost && pdn_s && $past(pdn_s)) |=> $stable(parallel_word_out)) // [R10]
    else $error("word changed while clock lost");
  pipe_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (fclk_rise && pdn_s && !clk_lost) |=> parallel_word_out == $past(stage1)) // [R5]
    else $error("word skipped a pipeline stage");
  strobe_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(regenerated_clock_out) |-> locked && $past(pdn_s)) // [R3]
    else $error("clock out rose while not running");
  lock_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    locked |-> $past(pdn_s, 2)) // [R6]
    else $error("locked during power-down");
  map_table_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    mapped[LVDSD_MAP[0]] == shadow[0]) // [R13]
    else $error("slot map mismatch");
endmodule

// ### lvdsd_pkg.sv
// Purpose: shared constants for the seven-to-one deserializer
// Assumes: system clock 200 MHz
// Notes: lane slot map is shared with the serializer side
package lvdsd_pkg;
  localparam int LVDSD_LANES = 4;
  localparam int LVDSD_SLOTS = 7;
  localparam int LVDSD_WORD_W = 28;
  localparam int LVDSD_SYS_PERIOD_PS = 5000;
  // power-down must take effect within 1 microsecond; this constant holds 1 ns
  localparam int LVDSD_PDN_DELAY_NS = 1;
  localparam int LVDSD_PDN_CYCLES = ((LVDSD_PDN_DELAY_NS * 1000) / LVDSD_SYS_PERIOD_PS) < 1 ? 1 :
    ((LVDSD_PDN_DELAY_NS * 1000) / LVDSD_SYS_PERIOD_PS);
  // lock window; longest time, rounded down
  localparam int LVDSD_LOCK_TIME_MS = 10;
  localparam int LVDSD_LOCK_CYCLES = (LVDSD_LOCK_TIME_MS * 1000000) / (LVDSD_SYS_PERIOD_PS / 1000);
  // slowest legal forwarded clock is 20 MHz: 50 ns, i.e. 10 system cycles
  localparam int LVDSD_FWD_MIN_MHZ = 20;
  localparam int LVDSD_CLK_LOST_CYCLES = (1000000 / LVDSD_FWD_MIN_MHZ) / LVDSD_SYS_PERIOD_PS * 2;
  // presentation delay in forwarded clock periods
  localparam int LVDSD_LATENCY = 2;
  // strobe positions use the mean of this many periods; a single period is too coarse at 200 MHz
  localparam int LVDSD_AVG_PERIODS = 5;
  localparam logic [2:0] LVDSD_LOCK_EDGES = 3'h4;
  // output bit position for lane l, slot s (index l*7+s)
  typedef logic [4:0] lvdsd_pos_t;
  localparam lvdsd_pos_t LVDSD_MAP [LVDSD_WORD_W] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
    5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B};
  typedef enum logic [1:0] {LVDSD_DOWN = 2'b00, LVDSD_SEEK = 2'b01, LVDSD_RUN = 2'b11} lvdsd_state_e;
endpackage

// ### lvdsd_tx_model.sv
// Purpose: serializer model that feeds the deserializer lanes
// Assumes: 64 ns forwarded clock, seven slots per period
// Notes: lanes float high and the clock stands low between frames
`timescale 1ns/1ps
module lvdsd_tx_model
  import lvdsd_pkg::*;
(
  input wire logic run,
  input wire logic lanes_on,
  output logic fclk,
  output logic [LVDSD_LANES-1:0] lanes,
  output int nframes
);
  logic [LVDSD_WORD_W-1:0] w;
  ////////////////////////////////////////////////////////////////////////
  // word sent in frame n; the bench derives its expectations from it
  function automatic logic [LVDSD_WORD_W-1:0] pat(input int n);
    pat = {7'(n * 3 + 1), 7'(n * 5 + 2), ~7'(n), 7'(n) ^ 7'h55};
  endfunction
  // a frame always finishes whole once started
  initial begin
    fclk = 1'b0;
    lanes = '1;
    nframes = 0;
    forever begin
      if (!run) begin
        fclk = 1'b0;
        lanes = '1;
        #2;
      end else begin
        nframes++;
        w = pat(nframes);
        for (int s = 0; s < LVDSD_SLOTS; s++) begin
          fclk = (s < 4);
          for (int l = 0; l < LVDSD_LANES; l++) begin
            lanes[l] = lanes_on ? w[LVDSD_MAP[l*LVDSD_SLOTS+s]] : 1'b1;
          end
          #(64.0 / LVDSD_SLOTS);
        end
      end
    end
  end
endmodule

// ### lvdsd_rx_tb.sv
// Purpose: self-checking bench for the seven-to-one deserializer
// Assumes: serializer model runs a 64 ns forwarded clock
// Notes: lock count shortened to 200 cycles to keep the run short
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("BAD %0t mismatch", $time); end end
module lvdsd_rx_tb
  import lvdsd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic power_down_n = 1'b1;
  logic run = 1'b0;
  logic lanes_on = 1'b1;
  logic fwd;
  logic [LVDSD_LANES-1:0] lanes;
  logic [LVDSD_WORD_W-1:0] word;
  logic regen;
  logic locked;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int m;
  int hi;
  int lo;
  lvdsd_tx_model tx_inst (.run(run), .lanes_on(lanes_on), .fclk(fwd), .lanes(lanes), .nframes());
  lvdsd_rx #(.LOCK_CYCLES(200), .PER_W(8)) lvdsd_rx_inst (.clk_sys(clk_sys), .rstn(rstn),
    .serial_data_lane(lanes), .forwarded_clock_in(fwd), .power_down_n(power_down_n),
    .parallel_word_out(word), .regenerated_clock_out(regen), .locked(locked));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs well under 10k cycles
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  // bounded wait for a rising edge of the output clock
  task automatic next_rise();
    for (int n = 0; n < 40 && regen !== 1'b0; n++) step();
    for (int n = 0; n < 40 && regen !== 1'b1; n++) step();
    m = tx_inst.nframes;
  endtask
  task automatic t_stream();
    run = 1'b1;
    for (int n = 0; n < 800 && locked !== 1'b1; n++) step();
    `CHK(locked, 1'b1)
    repeat (3) next_rise();
    for (int i = 0; i < 12; i++) begin
      next_rise();
      `CHK(word, tx_inst.pat(m - 2))
      for (hi = 0; hi < 20 && regen === 1'b1; hi++) step();
      `CHK(hi inside {[5:8]}, 1'b1)
      for (lo = 0; lo < 20 && regen === 1'b0; lo++) step();
      `CHK(lo inside {[5:8]}, 1'b1)
    end
  endtask
  // undriven lanes while the clock keeps running
  task automatic t_failsafe();
    lanes_on = 1'b0;
    repeat (4) next_rise();
    `CHK(word, {LVDSD_WORD_W{1'b1}})
    lanes_on = 1'b1;
    repeat (4) next_rise();
  endtask
  // clock and lanes both go away: word holds, clock out low
  task automatic t_loss();
    run = 1'b0;
    repeat (60) step();
    m = tx_inst.nframes;
    `CHK(regen, 1'b0)
    `CHK(word, tx_inst.pat(m - 2))
  endtask
  task automatic t_pdown();
    t_stream();
    power_down_n = 1'b0;
    repeat (3) step();
    for (int i = 0; i < 30; i++) begin
      `CHK({regen, word}, '0)
      step();
    end
    power_down_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) step();
    `CHK({regen, word, locked}, '0)
    rstn = 1'b1;
    t_stream();
    t_failsafe();
    t_loss();
    t_pdown();
    stop_test();
  end
endmodule
